/* rtl/rst_pwr_pkg.sv */
// constants for the reset and power mode controller
package rst_pwr_pkg;
  // register byte addresses (printed offsets kept as indices)
  localparam logic [7:0]  PWRCTL_IDX     = 8'h87;
  localparam logic [7:0]  CHIPCFG_IDX    = 8'hbf;
  localparam logic [11:0] ADDR_POWER_CTL = {2'b00, PWRCTL_IDX, 2'b00};
  localparam logic [11:0] ADDR_CHIP_CFG  = {2'b00, CHIPCFG_IDX, 2'b00};
  localparam logic [11:0] ADDR_STATUS    = 12'h400;
  // power_control fields
  localparam int IDLE_BIT  = 0;
  localparam int STOP_BIT  = 1;
  localparam int FLAGA_BIT = 2;
  localparam int FLAGB_BIT = 3;
  localparam int BAUD_BIT  = 7;
  localparam logic [7:0] PWRCTL_WMASK = 8'h8f;
  localparam logic [7:0] PWRCTL_RST   = 8'h00;
  // chip_configuration fields
  localparam int LV_DIS_BIT = 0;
  localparam logic [7:0] CHIPCFG_RST = 8'h00;
  // reset stretch and sampling
  localparam int STRETCH_COUNT = 2048;
  localparam int STRETCH_W     = 12;
  localparam int STATES_PER_CYCLE = 4;
  localparam int EXT_RST_CYCLES   = 2;
  typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_STOP} pmode_t;
endpackage

/* rtl/reset_and_power_mode_ctrl.sv */
// reset merge, reset stretch and idle/stop mode control with apb registers
`timescale 1ns/1ps
`default_nettype none
module reset_and_power_mode_ctrl
  import rst_pwr_pkg::*;
#(
  parameter int STRETCH = STRETCH_COUNT
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        ext_reset_pin,
  input  wire logic        power_on_pulse,
  input  wire logic        low_voltage_detect,
  input  wire logic        watchdog_overflow,
  input  wire logic        isp_reset,
  input  wire logic        watchdog_enabled,
  input  wire logic        osc_stable,
  input  wire logic        state4_tick,
  input  wire logic        wake_interrupt,
  input  wire logic        ext_memory,
  output logic             internal_reset,
  output logic             cpu_halt,
  output logic             osc_stop,
  output logic             baud_doubler,
  output logic             strobe_override,
  output logic             strobe_level,
  output logic             port0_float,
  output logic             port2_address
);
  // pin-side inputs pass two flops
  logic [1:0] pin_s_r, por_s_r, lvd_s_r, osc_s_r;
  logic       pin_q, por_q, lvd_q, osc_q;
  assign pin_q = pin_s_r[1];
  assign por_q = por_s_r[1];
  assign lvd_q = lvd_s_r[1];
  assign osc_q = osc_s_r[1];
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_s_r <= 2'b00;
      por_s_r <= 2'b00;
      lvd_s_r <= 2'b00;
      osc_s_r <= 2'b00;
    end else begin
      pin_s_r <= {pin_s_r[0], ext_reset_pin};
      por_s_r <= {por_s_r[0], power_on_pulse};
      lvd_s_r <= {lvd_s_r[0], low_voltage_detect};
      osc_s_r <= {osc_s_r[0], osc_stable};
    end
  end

  // registers
  logic [7:0] power_control_r;
  logic [7:0] chip_configuration_r;
  pmode_t     mode_r, mode_nxt;

  // pin sampled on the fourth state; two consecutive high samples needed
  logic [1:0] pin_cnt_r;
  logic       pin_rst;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_cnt_r <= 2'd0;
    end else if (state4_tick) begin
      if (!pin_q)
        pin_cnt_r <= 2'd0;
      else if (pin_cnt_r != 2'(EXT_RST_CYCLES))
        pin_cnt_r <= pin_cnt_r + 2'd1;
    end
  end
  assign pin_rst = (pin_cnt_r == 2'(EXT_RST_CYCLES));

  wire lv_rst_en = ~chip_configuration_r[LV_DIS_BIT];
  wire cause_any = pin_rst | por_q | (lv_rst_en & lvd_q)
                 | watchdog_overflow | isp_reset;

  // stretch counter; the pulse zeroes it, oscillator clocks advance it
  logic [STRETCH_W-1:0] stretch_r;
  logic                 stretch_done_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || cause_any) begin
      stretch_r      <= '0;
      stretch_done_r <= 1'b0;
    end else if (!stretch_done_r && osc_q) begin
      if (stretch_r == STRETCH_W'(STRETCH - 1))
        stretch_done_r <= 1'b1;
      else
        stretch_r <= stretch_r + 1'b1;
    end
  end
  // reset stays high until every cause clears and stretch_done_r sets, one clock after the stretch count reaches STRETCH - 1
  assign internal_reset = sys_rst | cause_any | ~stretch_done_r;

  // apb decode
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire hit_pwr  = (paddr == ADDR_POWER_CTL);
  wire hit_cfg  = (paddr == ADDR_CHIP_CFG);
  wire hit_stat = (paddr == ADDR_STATUS);
  wire mapped   = hit_pwr | hit_cfg | hit_stat;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // stop refused while watchdog runs: the request bit is not stored
  wire [7:0] pwr_wr  = pwdata[7:0] & PWRCTL_WMASK
                     & ~({7'd0, watchdog_enabled} << STOP_BIT);
  wire idle_wake = (mode_r == MODE_IDLE) & wake_interrupt;

  always_ff @(posedge sys_clk) begin
    if (internal_reset) begin
      power_control_r <= PWRCTL_RST;
    end else if (wr && hit_pwr) begin
      power_control_r <= pwr_wr;
    end else if (idle_wake) begin
      power_control_r[IDLE_BIT] <= 1'b0;
    end
  end

  // configuration only reset by the system reset so disable survives
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      chip_configuration_r <= CHIPCFG_RST;
    else if (wr && hit_cfg)
      chip_configuration_r <= pwdata[7:0];
  end

  // mode selection; idle returns to run on wake, stop holds until internal reset
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_RUN: begin
        if (power_control_r[STOP_BIT])
          mode_nxt = MODE_STOP;
        else if (power_control_r[IDLE_BIT])
          mode_nxt = MODE_IDLE;
      end
      MODE_IDLE: begin
        if (power_control_r[STOP_BIT])
          mode_nxt = MODE_STOP;
        else if (!power_control_r[IDLE_BIT])
          mode_nxt = MODE_RUN;
      end
      MODE_STOP: mode_nxt = MODE_STOP;
      default:   mode_nxt = MODE_RUN;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (internal_reset)
      mode_r <= MODE_RUN;
    else
      mode_r <= mode_nxt;
  end

  wire in_idle = (mode_r == MODE_IDLE);
  wire in_stop = (mode_r == MODE_STOP);
  // idle halts cpu and overrides the strobes high but leaves the oscillator running; peripherals keep their own clocks
  assign cpu_halt        = in_idle | in_stop;
  assign osc_stop        = in_stop;
  assign baud_doubler    = power_control_r[BAUD_BIT];
  assign strobe_override = in_idle | in_stop;
  assign strobe_level    = in_idle;
  assign port0_float     = (in_idle | in_stop) & ext_memory;
  assign port2_address   = ~in_stop & ext_memory;

  // read data registered
  wire [31:0] rd_mux = hit_pwr  ? {24'd0, power_control_r}
                     : hit_cfg  ? {24'd0, chip_configuration_r}
                     : hit_stat ? {29'd0, stretch_done_r, mode_r}
                     : 32'h0000_0000;
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end
endmodule
`default_nettype wire

/* dv/reset_and_power_mode_ctrl_assertions.sv */
// checker for the reset and power mode controller ports
`timescale 1ns/1ps
`default_nettype none
module rpm_assertions
  import rst_pwr_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        watchdog_overflow,
  input wire logic        watchdog_enabled,
  input wire logic        ext_memory,
  input wire logic        internal_reset,
  input wire logic        cpu_halt,
  input wire logic        osc_stop,
  input wire logic        strobe_override,
  input wire logic        strobe_level,
  input wire logic        port0_float,
  input wire logic        port2_address
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_pready_high: assert property (pready) else $error("pready low");
  a_slverr_unmap: assert property (psel && penable && paddr != ADDR_POWER_CTL
    && paddr != ADDR_CHIP_CFG && paddr != ADDR_STATUS |-> pslverr)
    else $error("unmapped access not refused");
  a_wdog_reset: assert property (watchdog_overflow |-> ##[0:3] internal_reset)
    else $error("watchdog overflow gave no reset");
  a_stop_strobe: assert property (osc_stop
    |-> strobe_override && !strobe_level)
    else $error("strobes not low in stop");
  a_idle_strobe: assert property (cpu_halt && !osc_stop && !internal_reset
    |-> strobe_override && strobe_level) else $error("idle strobes");
  a_port0_float: assert property (strobe_override && ext_memory
    |-> port0_float)
    else $error("port0 not floating");
  a_port2_stop: assert property (osc_stop |-> !port2_address)
    else $error("port2 address in stop");
  a_stop_wdog: assert property (osc_stop |-> !watchdog_enabled)
    else $error("stop with watchdog on");
endmodule
`default_nettype wire

/* dv/cpu_side_model.sv */
// cpu side model: instruction state ticks and oscillator status
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  output logic      state4_tick,
  output logic      osc_stable
);
  logic [1:0] ph_r;
  always_ff @(posedge sys_clk) ph_r <= sys_rst ? 2'h0 : ph_r + 2'h1;
  assign state4_tick = (ph_r == 2'h3);
  // stable only after reset, so stretch never starts early
  assign osc_stable = !sys_rst;
endmodule
`default_nettype wire

/* dv/reset_and_power_mode_ctrl_tb_top.sv */
// testbench for the reset and power mode controller
`timescale 1ns/1ps
`default_nettype none
module reset_and_power_mode_ctrl_tb_top;
  import rst_pwr_pkg::*;
  logic sys_clk = '0, sys_rst = '1, psel = '0, penable = '0, pwrite = '0, er;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, ext_reset_pin = '0, power_on_pulse = '0;
  logic isp_reset = '0;
  logic low_voltage_detect = '0, watchdog_overflow = '0, watchdog_enabled = '0;
  logic wake_interrupt = '0, ext_memory = '0, osc_stable, state4_tick;
  logic osc_stop;
  logic internal_reset, cpu_halt, baud_doubler, strobe_override, strobe_level;
  logic port0_float, port2_address;
  int bad_count = 0, cmp_count = 0, cyc = 0, n = 0;
  reset_and_power_mode_ctrl #(.STRETCH(8)) u_reset_and_power_mode_ctrl (.*);
  cpu_side_model u_cpu_side_model (.*);
  always #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge sys_clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge sys_clk) penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    q = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic wt(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  task automatic wake;
    @(posedge sys_clk) wake_interrupt <= 1'b1;
    @(posedge sys_clk) wake_interrupt <= 1'b0;
    wt(3);
  endtask
  task automatic rel;
    while (internal_reset !== 1'b0) @(negedge sys_clk);
  endtask
  task wrap_up;
    $display("mismatches %0d compares %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      wrap_up;
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    while (internal_reset !== 1'b0) begin
      @(negedge sys_clk) n++;
    end
    chk(n > 8 && n < 24, 32'h1);
    apb(ADDR_POWER_CTL, 1, 32'hfc);
    apb(ADDR_POWER_CTL, 0, 32'h0);
    chk(q, 32'h8c);
    chk(baud_doubler, 32'h1);
    apb(12'h010, 0, 32'h0);
    chk({er, q[30:0]}, 32'h80000000);
    ext_memory <= 1'b1;
    apb(ADDR_POWER_CTL, 1, 32'h01);
    wt(2);
    chk({cpu_halt, osc_stop, port0_float, port2_address}, 32'hb);
    wake;
    apb(ADDR_POWER_CTL, 0, 32'h0);
    chk({cpu_halt, q[7:0]}, 32'h0);
    @(posedge sys_clk) watchdog_enabled <= 1'b1;
    apb(ADDR_POWER_CTL, 1, 32'h03);
    wt(2);
    chk({cpu_halt, osc_stop}, 32'h2);
    wake;
    @(posedge sys_clk) watchdog_enabled <= 1'b0;
    apb(ADDR_POWER_CTL, 1, 32'h03);
    wt(2);
    chk({osc_stop, port2_address}, 32'h2);
    wake;
    chk(osc_stop, 32'h1);
    // pin held over three state ticks, past the two-cycle minimum
    @(posedge sys_clk) ext_reset_pin <= 1'b1;
    repeat (12) @(posedge sys_clk);
    ext_reset_pin <= 1'b0;
    rel;
    apb(ADDR_POWER_CTL, 0, 32'h0);
    chk({osc_stop, q[7:0]}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk) {power_on_pulse, watchdog_overflow, isp_reset,
        low_voltage_detect} <= 4'h1 << i;
      wt(5);
      chk(internal_reset, 32'h1);
      @(posedge sys_clk) {power_on_pulse, watchdog_overflow, isp_reset,
        low_voltage_detect} <= 4'h0;
      rel;
    end
    apb(ADDR_CHIP_CFG, 1, 32'h1);
    low_voltage_detect <= 1'b1;
    wt(6);
    chk(internal_reset, 32'h0);
    wrap_up;
  end
endmodule
bind reset_and_power_mode_ctrl rpm_assertions u_rpm_assertions (.*);
`default_nettype wire
